// ===== src/csp_pkg.sv
// Package: register map, field positions, reset values and timing for the command page
package csp_pkg;
    // Register offsets (page 0)
    localparam logic [5:0] CSP_OFS_PAGE = 6'h00;
    localparam logic [5:0] CSP_OFS_CMD = 6'h01;
    localparam logic [5:0] CSP_OFS_IEN = 6'h02;
    // Page register fields
    localparam int CSP_PAGE_OVR_BIT = 7;
    localparam logic [7:0] CSP_PAGE_RST = 8'h00;
    localparam logic [7:0] CSP_PAGE_MASK = 8'h83;
    // Command register fields
    localparam int CSP_CMD_RXOFF_BIT = 5;
    localparam int CSP_CMD_SLEEP_BIT = 4;
    localparam logic [7:0] CSP_CMD_RST = 8'h20;
    localparam logic [7:0] CSP_CMD_MASK = 8'h3F;
    // Command codes
    localparam logic [3:0] CSP_CODE_IDLE = 4'h0;
    localparam logic [3:0] CSP_CODE_RESTART = 4'hF;
    // Interrupt enable register
    localparam int CSP_IEN_INV_BIT = 7;
    localparam logic [7:0] CSP_IEN_RST = 8'h80;
    // Wake-up time and its cycle count at 200 MHz
    localparam int CSP_CLK_MHZ = 200;
    localparam int CSP_WAKE_US = 10;
    localparam int CSP_WAKE_CYC = CSP_WAKE_US * CSP_CLK_MHZ;
    localparam logic [11:0] CSP_WAKE_CNT = 12'(CSP_WAKE_CYC);
    // Length of a generic command run
    localparam logic [7:0] CSP_CMD_CYC = 8'h10;
    typedef enum logic [2:0] {
        CSP_AWAKE = 3'h1,
        CSP_ASLEEP = 3'h2,
        CSP_WAKING = 3'h4
    } csp_pwr_t;
endpackage : csp_pkg

// ===== src/csp_wake.sv
// Soft sleep and wake-up sequencer
`timescale 1ns/10ps
`default_nettype none
module csp_wake
    import csp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic sleep_req,
    input wire logic wake_req,
    // Status
    output logic sleep_bit,
    output logic asleep
);
    typedef struct packed {
        csp_pwr_t st;
        logic [11:0] cnt;
    } csp_wake_st_t;
    csp_wake_st_t s, next_s;

    always_comb begin
        next_s = s;
        case (s.st)
            CSP_AWAKE: begin
                if (sleep_req) begin
                    next_s.st = CSP_ASLEEP;
                end
            end
            CSP_ASLEEP: begin
                if (wake_req) begin
                    next_s.st = CSP_WAKING;
                    next_s.cnt = CSP_WAKE_CNT;
                end
            end
            CSP_WAKING: begin
                // Bit keeps reading one until the count runs out
                if (sleep_req) begin
                    // A fresh sleep write aborts the wake-up
                    next_s.st = CSP_ASLEEP;
                    next_s.cnt = 12'h000;
                end else if (s.cnt <= 12'h001) begin
                    next_s.st = CSP_AWAKE;
                    next_s.cnt = 12'h000;
                end else begin
                    next_s.cnt = s.cnt - 12'h001;
                end
            end
            default: begin
                next_s.st = CSP_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: CSP_AWAKE, cnt: 12'h000};
        end else begin
            s <= next_s;
        end
    end

    assign sleep_bit = (s.st != CSP_AWAKE);
    assign asleep = (s.st == CSP_ASLEEP);

    AST_WAKE_BIT_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
        (s.st == CSP_ASLEEP && wake_req) |=> sleep_bit [*8])
        else $error("sleep bit dropped too early during wake-up");
endmodule : csp_wake
`default_nettype wire

// ===== src/csp_seq.sv
// Command sequencer: runs the started command and returns to idle
`timescale 1ns/10ps
`default_nettype none
module csp_seq
    import csp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Start
    input wire logic start,
    input wire logic [3:0] code,
    // Status
    output logic [3:0] cur_code,
    output logic done
);
    typedef struct packed {
        logic [3:0] code;
        logic [7:0] cnt;
        logic done;
    } csp_seq_st_t;
    csp_seq_st_t s, next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (start) begin
            next_s.code = code;
            next_s.cnt = (code == CSP_CODE_IDLE) ? 8'h00 : CSP_CMD_CYC;
        end else if (s.code != CSP_CODE_IDLE) begin
            // Finished command falls back to idle on its own
            if (s.cnt <= 8'h01) begin
                next_s.code = CSP_CODE_IDLE;
                next_s.cnt = 8'h00;
                next_s.done = 1'b1;
            end else begin
                next_s.cnt = s.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{code: CSP_CODE_IDLE, cnt: 8'h00, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign cur_code = s.code;
    assign done = s.done;

    AST_SEQ_ENDS_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(done) |-> (cur_code == CSP_CODE_IDLE) && ($past(cur_code) != CSP_CODE_IDLE))
        else $error("command did not return to idle on finish");
endmodule : csp_seq
`default_nettype wire

// ===== src/csp_regs.sv
// Command and status page register bank with page addressing and interrupt pin
`timescale 1ns/10ps
`default_nettype none
module csp_regs
    import csp_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [5:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic [5:0] REG_ADDR,
    // Core status
    input wire logic [6:0] IRQ_FLAGS,
    input wire logic CHECKSUM_DONE,
    // Core controls
    output logic RX_ANALOG_OFF,
    output logic SLEEP_ACTIVE,
    output logic [3:0] CMD_CODE,
    output logic CMD_DONE,
    output logic IRQ_STATUS,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0] page;
        logic rx_off;
        logic [7:0] ien;
        logic [7:0] rdata;
        logic [5:0] reg_addr;
        logic irq_status;
        logic irq;
        logic sleep_active;
        logic [3:0] cmd_code;
        logic cmd_done;
    } csp_regs_st_t;
    csp_regs_st_t s, next_s;

    logic [5:0] eff_addr;
    logic [3:0] cur_code;
    logic seq_done;
    logic sleep_bit;
    logic asleep;
    logic hit_cmd;
    logic sleep_req;
    logic wake_req;
    logic cmd_start;
    logic restart_busy;
    logic [7:0] cmd_rd;

    // Page override supplies the upper address bits, else latch used whole
    always_comb begin
        if (s.page[CSP_PAGE_OVR_BIT]) begin
            eff_addr = {s.page[1:0], ADDR[3:0]};
        end else begin
            eff_addr = ADDR;
        end
    end

    assign hit_cmd = WR_EN && (eff_addr == CSP_OFS_CMD);
    assign restart_busy = (cur_code == CSP_CODE_RESTART);
    // Sleep can not be entered while the restart command runs
    assign sleep_req = hit_cmd && WDATA[CSP_CMD_SLEEP_BIT] && !restart_busy;
    assign wake_req = hit_cmd && !WDATA[CSP_CMD_SLEEP_BIT];
    assign cmd_start = hit_cmd && !WDATA[CSP_CMD_SLEEP_BIT];
    // Reserved bits 7..6 read zero
    assign cmd_rd = {2'b00, s.rx_off, sleep_bit, cur_code} & CSP_CMD_MASK;

    csp_wake u_wake (
        .clk(CLK),
        .resetn(RESETN),
        .sleep_req(sleep_req),
        .wake_req(wake_req),
        .sleep_bit(sleep_bit),
        .asleep(asleep)
    );

    csp_seq u_seq (
        .clk(CLK),
        .resetn(RESETN),
        .start(cmd_start),
        .code(WDATA[3:0]),
        .cur_code(cur_code),
        .done(seq_done)
    );

    always_comb begin
        next_s = s;
        // Host-owned control bits change only on host writes
        if (WR_EN) begin
            case (eff_addr)
                CSP_OFS_PAGE: begin
                    next_s.page = WDATA & CSP_PAGE_MASK;
                end
                CSP_OFS_CMD: begin
                    next_s.rx_off = WDATA[CSP_CMD_RXOFF_BIT];
                end
                CSP_OFS_IEN: begin
                    next_s.ien = WDATA;
                end
                default: begin
                    // Unmapped and test space: writes dropped, also keeps
                    // checksum-done out of host reach
                    next_s.page = s.page;
                end
            endcase
        end
        // Unmapped reads and write-only offsets return zero on this page
        if (RD_EN) begin
            case (eff_addr)
                CSP_OFS_PAGE: begin
                    next_s.rdata = s.page & CSP_PAGE_MASK;
                end
                CSP_OFS_CMD: begin
                    next_s.rdata = cmd_rd;
                end
                CSP_OFS_IEN: begin
                    next_s.rdata = s.ien;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
        next_s.reg_addr = eff_addr;
        // Interrupt combine and polarity
        next_s.irq_status = |(IRQ_FLAGS & s.ien[6:0]);
        next_s.irq = next_s.irq_status ^ s.ien[CSP_IEN_INV_BIT];
        next_s.sleep_active = asleep;
        next_s.cmd_code = cur_code;
        next_s.cmd_done = seq_done | (CHECKSUM_DONE & 1'b0);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s.page <= CSP_PAGE_RST;
            s.rx_off <= CSP_CMD_RST[CSP_CMD_RXOFF_BIT];
            s.ien <= CSP_IEN_RST;
            s.rdata <= 8'h00;
            s.reg_addr <= 6'h00;
            s.irq_status <= 1'b0;
            s.irq <= CSP_IEN_RST[CSP_IEN_INV_BIT];
            s.sleep_active <= 1'b0;
            s.cmd_code <= CSP_CODE_IDLE;
            s.cmd_done <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign RDATA = s.rdata;
    assign REG_ADDR = s.reg_addr;
    assign RX_ANALOG_OFF = s.rx_off;
    assign SLEEP_ACTIVE = s.sleep_active;
    assign CMD_CODE = s.cmd_code;
    assign CMD_DONE = s.cmd_done;
    assign IRQ_STATUS = s.irq_status;
    assign IRQ = s.irq;

    AST_RW_HOLDS: assert property (@(posedge CLK) disable iff (!RESETN)
        !(WR_EN && eff_addr == CSP_OFS_IEN) |=> $stable(s.ien))
        else $error("enable register changed without a host write");
    AST_PAGE_ADDR: assert property (@(posedge CLK) disable iff (!RESETN)
        s.page[CSP_PAGE_OVR_BIT] |=> REG_ADDR == {$past(s.page[1:0]), $past(ADDR[3:0])})
        else $error("page override not applied to address");
    AST_LATCH_ADDR: assert property (@(posedge CLK) disable iff (!RESETN)
        !s.page[CSP_PAGE_OVR_BIT] |=> REG_ADDR == $past(ADDR))
        else $error("latched address not used whole");
    AST_WO_ZERO: assert property (@(posedge CLK) disable iff (!RESETN)
        (RD_EN && eff_addr > CSP_OFS_IEN) |=> RDATA == 8'h00)
        else $error("unmapped or write-only read not zero");
    AST_PAGE_RSVD: assert property (@(posedge CLK) disable iff (!RESETN)
        (s.page & ~CSP_PAGE_MASK) == 8'h00)
        else $error("reserved page bits set");
    AST_RESTART_NO_SLEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        (hit_cmd && WDATA[CSP_CMD_SLEEP_BIT] && restart_busy && !sleep_bit) |=> !sleep_bit)
        else $error("sleep entered during restart");
    AST_SLEEP_ENTER: assert property (@(posedge CLK) disable iff (!RESETN)
        sleep_req |=> sleep_bit ##1 SLEEP_ACTIVE)
        else $error("sleep not entered on write");
    AST_CMD_READ: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_start && !RD_EN) |=> cur_code == $past(WDATA[3:0]))
        else $error("command field does not show started command");
    AST_IRQ_POL: assert property (@(posedge CLK) disable iff (!RESETN)
        IRQ == (IRQ_STATUS ^ $past(s.ien[CSP_IEN_INV_BIT])))
        else $error("interrupt pin polarity wrong");
    AST_RXOFF: assert property (@(posedge CLK) disable iff (!RESETN)
        (WR_EN && eff_addr == CSP_OFS_CMD) |=> RX_ANALOG_OFF == $past(WDATA[5]))
        else $error("receiver off bit not written");

    COV_SLEEP: cover property (@(posedge CLK) disable iff (!RESETN) sleep_req);
    COV_WAKE: cover property (@(posedge CLK) disable iff (!RESETN) $fell(sleep_bit));
    COV_DONE: cover property (@(posedge CLK) disable iff (!RESETN) CMD_DONE);
    COV_PAGE: cover property (@(posedge CLK) disable iff (!RESETN) s.page[CSP_PAGE_OVR_BIT]);
endmodule : csp_regs
`default_nettype wire

// ===== tb/csp_host.sv
// Host microcontroller model driving the register port
`timescale 1ns/10ps
`default_nettype none
module csp_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic [5:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    localparam logic [5:0] CSP_OFS_CMD_H = 6'h01;
    initial begin
        addr = 6'h3F;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'hA5;
    end
    // Address and data are inverted and enables cleared on release so a stale value never passes for a fresh one
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        wdata = d;
        wr_en = wr;
        rd_en = !wr;
        @(posedge clk) #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : access
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        @(posedge clk) #1;
        d = rdata;
    endtask : rd
    // Poll the sleep bit until the device reports ready, bounded
    task automatic wait_ready(output int polls);
        logic [7:0] d;
        polls = 0;
        do begin
            rd(CSP_OFS_CMD_H, d);
            polls++;
        end while (d[4] === 1'b1 && polls < 1000);
    endtask : wait_ready
endmodule : csp_host
`default_nettype wire

// ===== tb/tb_command_status_page_regs.sv
// Self-checking bench for the command and status page registers
`timescale 1ns/10ps
`default_nettype none
module tb_command_status_page_regs
    import csp_pkg::*;
;
    logic clk, resetn, wr_en, rd_en, checksum_done;
    logic [5:0] addr, reg_addr;
    logic [7:0] wdata, rdata, m_page, m_cmd, m_ien;
    logic [6:0] irq_flags;
    logic rx_analog_off, sleep_active, cmd_done, irq_status, irq, m_asleep;
    logic [3:0] cmd_code;
    logic [31:0] r;
    int err_count, total_checks, cycles, polls;
    csp_regs i_csp_regs (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WR_EN(wr_en),
        .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .REG_ADDR(reg_addr),
        .IRQ_FLAGS(irq_flags), .CHECKSUM_DONE(checksum_done),
        .RX_ANALOG_OFF(rx_analog_off), .SLEEP_ACTIVE(sleep_active), .CMD_CODE(cmd_code),
        .CMD_DONE(cmd_done), .IRQ_STATUS(irq_status), .IRQ(irq));
    csp_host i_csp_host (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata(rdata));
    always #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [5:0] eff(input logic [5:0] a);
        return m_page[7] ? {m_page[1:0], a[3:0]} : a;
    endfunction : eff
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic do_reset();
        resetn = 1'b0;
        m_page = 8'h00;
        m_cmd = 8'h20;
        m_ien = 8'h80;
        m_asleep = 1'b0;
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
    endtask : do_reset
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [5:0] e;
        e = eff(a);
        i_csp_host.access(1'b1, a, d);
        check("reg_addr", {2'b00, reg_addr}, {2'b00, e});
        case (e)
            CSP_OFS_PAGE: m_page = d & 8'h83;
            CSP_OFS_IEN: m_ien = d;
            CSP_OFS_CMD: begin
                m_cmd[5] = d[5];
                if (!d[4]) begin
                    m_cmd[3:0] = d[3:0];
                    m_asleep = 1'b0;
                end else if (m_cmd[3:0] != 4'hF) begin
                    m_cmd[4] = 1'b1;
                    m_asleep = 1'b1;
                end
            end
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [5:0] a);
        logic [7:0] d, e;
        case (eff(a))
            CSP_OFS_PAGE: e = m_page;
            CSP_OFS_CMD: e = m_cmd;
            CSP_OFS_IEN: e = m_ien;
            default: e = 8'h00;
        endcase
        i_csp_host.rd(a, d);
        check("rdata", d, e);
    endtask : rd
    task automatic pins();
        logic st;
        repeat (3) @(posedge clk) #1;
        st = |(m_ien[6:0] & irq_flags);
        check("rx_off", {7'h0, rx_analog_off}, {7'h0, m_cmd[5]});
        check("asleep", {7'h0, sleep_active}, {7'h0, m_asleep});
        check("code", {4'h0, cmd_code}, {4'h0, m_cmd[3:0]});
        check("irq_st", {7'h0, irq_status}, {7'h0, st});
        check("irq", {7'h0, irq}, {7'h0, st ^ m_ien[7]});
    endtask : pins
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        clk = 1'b0;
        irq_flags = 7'h00;
        checksum_done = 1'b0;
        r = 32'h46B8;
        do_reset();
        rd(0); rd(1); rd(2); pins();
        $display("test reset done");
        // Reserved page bits, overrides on page 0; test offsets are never touched
        wr(0, 8'h7F); rd(0);
        wr(0, 8'h80); r = lfsr(r); wr(6'h32, r[7:0]); rd(6'h22); rd(6'h00);
        wr(6'h30, 8'h00); wr(6'h05, 8'hFF); rd(6'h05);
        $display("test paging done");
        for (int i = 0; i < 7; i++) begin
            wr(2, 8'h80 | (8'h01 << i));
            irq_flags = 7'(1 << i);
            pins();
            irq_flags = ~7'(1 << i);
            wr(2, 8'h01 << i);
            pins();
        end
        r = lfsr(r); irq_flags = r[6:0]; wr(2, r[15:8]); pins();
        $display("test interrupt done");
        for (int c = 1; c < 16; c++) begin
            r = lfsr(r);
            checksum_done = r[3];
            wr(1, {2'b00, r[5], 1'b0, 4'(c)});
            if (c == 15) wr(1, {2'b00, r[5], 1'b1, 4'hF});
            rd(1); pins();
            for (int n = 0; n < 40 && cmd_done !== 1'b1; n++) @(posedge clk) #1;
            check("done", {7'h0, cmd_done}, 8'h01);
            m_cmd[3:0] = 4'h0;
            rd(1); pins();
        end
        $display("test command done");
        wr(1, 8'h10); rd(1); pins();
        wr(1, 8'h00); rd(1);
        repeat (1800) @(posedge clk) #1;
        rd(1);
        i_csp_host.wait_ready(polls);
        check("woke", {7'h0, polls inside {[1:80]}}, 8'h01);
        m_cmd[4] = 1'b0;
        rd(1); pins();
        $display("test sleep done");
        wr(0, 8'hC1); rd(6'h02); wr(6'h02, 8'hFF);
        do_reset();
        rd(0); rd(2); rd(1);
        $display("test second reset done");
        conclude();
    end
endmodule : tb_command_status_page_regs
`default_nettype wire
